// ===== logic/tsx_executor.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] AND, OR, XOR replace the test register with old value op operand.
// [R2] Boolean operands are sixteen bits wide, like the test register.
// [R3] Conditional branches read the test register and never change it.
// [R4] The unconditional jump always loads its target.
// [R5] Match branches on equality, mismatch on inequality, else fall through.
// [R6] Above branches only when test register is strictly greater.
// [R7] Below branches only when test register is strictly less.
// [R8] At-least branches on greater or equal, at-most on less or equal.
// [R9] Empty branches on all-zero register, nonempty on any set bit.
// [R10] Bits-clear branches when register AND operand is zero, bits-any else.
// [R11] Targets may lie before or after the branching instruction.
// [R12] Jitter and eye results arrive in 1/64 ns raw units.
// [R13] Amplitude results arrive in 10 mV raw units.
// [R14] Sample-rate error results arrive in 1/64 Hz raw units.
// [R15] Phase results arrive in 360/512 degree raw units.
// [R16] One verdict flag; dedicated instructions force it good or bad.
// [R17] Segment end with a bad verdict aborts the whole sequence.
// [R18] Segment end with a good verdict lets the sequence continue unless it is the last segment.
// [R19] Verdict branches jump when the flag matches, else fall through.
// [R20] Message sends its text to display row two.
// [R21] No-operation has no effect and advances to the next instruction.
// [R22] Wait stalls for its operand in tenths of a second.
// [R23] Single-bit tests load bit zero and clear the upper fifteen bits.
// [R24] Segment end moves on, or ends the sequence when last or failed.
// [R25] Targets are absolute store addresses loaded into the counter.
module tsx_executor
  import tsx_pkg::*;
#(
  parameter int TENTH_CYCLES = TSX_TENTH_CYC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  output logic [11:0] fetch_addr_out,
  output logic fetch_req_out,
  input wire logic fetch_valid_in,
  input wire logic [5:0] instr_op_in,
  input wire logic [15:0] instr_operand_in,
  input wire logic [11:0] instr_target_in,
  input wire logic instr_last_seg_in,
  input wire logic [7:0] instr_msg_in,
  output logic meas_req_out,
  output logic [7:0] meas_sel_out,
  input wire logic meas_done_in,
  input wire logic [15:0] meas_result_in,
  input wire logic meas_bit_in,
  output logic msg_valid_out,
  output logic [7:0] msg_row_out,
  output logic [7:0] msg_text_out,
  output logic [15:0] test_reg_out,
  output logic verdict_good_out,
  output logic running_out,
  output logic aborted_out,
  output logic done_out
);
  typedef struct packed {
    tsx_state_t state;
    logic [11:0] pc;
    logic [15:0] test_reg;
    logic verdict_good;
    logic [15:0] wait_tenths;
    logic [31:0] wait_cyc;
    logic fetch_req;
    logic meas_req;
    logic [7:0] meas_sel;
    logic bit_only;
    logic msg_valid;
    logic [7:0] msg_text;
    logic aborted;
    logic done;
    logic [7:0] msg_row;
    logic running;
  } tsx_regs_t;

  tsx_regs_t cur_ff;
  tsx_regs_t nxt_cur;
  logic rst_sync_ff;
  logic rst_meta_ff;
  logic rst_n;
  logic taken;
  logic [11:0] pc_inc;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;
  assign pc_inc = cur_ff.pc + 12'h001;

  always_comb begin
    taken = 1'b0;
    case (instr_op_in)
      // [R4] Unconditional jump.
      TSX_OP_ALWAYS: taken = 1'b1;
      // [R5] Equality tests.
      TSX_OP_MATCH: taken = cur_ff.test_reg == instr_operand_in;
      TSX_OP_MISMATCH: taken = cur_ff.test_reg != instr_operand_in;
      // [R6] Strictly greater.
      TSX_OP_ABOVE: taken = cur_ff.test_reg > instr_operand_in;
      // [R7] Strictly less.
      TSX_OP_BELOW: taken = cur_ff.test_reg < instr_operand_in;
      // [R8] Inclusive comparisons.
      TSX_OP_AT_LEAST: taken = cur_ff.test_reg >= instr_operand_in;
      TSX_OP_AT_MOST: taken = cur_ff.test_reg <= instr_operand_in;
      // [R9] Zero tests on the whole register.
      TSX_OP_EMPTY: taken = cur_ff.test_reg == TSX_ZERO;
      TSX_OP_NONEMPTY: taken = cur_ff.test_reg != TSX_ZERO;
      // [R10] Masked tests.
      TSX_OP_BITS_CLEAR: taken = (cur_ff.test_reg & instr_operand_in) == TSX_ZERO;
      TSX_OP_BITS_ANY: taken = (cur_ff.test_reg & instr_operand_in) != TSX_ZERO;
      // [R19] Verdict tests.
      TSX_OP_VERDICT_GOOD: taken = cur_ff.verdict_good;
      TSX_OP_VERDICT_BAD: taken = !cur_ff.verdict_good;
      default: taken = 1'b0;
    endcase
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.msg_valid = 1'b0;
    nxt_cur.meas_req = 1'b0;
    case (cur_ff.state)
      TSX_IDLE: begin
        if (start_in) begin
          nxt_cur.pc = TSX_PC_RST;
          nxt_cur.verdict_good = 1'b1;
          nxt_cur.aborted = 1'b0;
          nxt_cur.done = 1'b0;
          nxt_cur.fetch_req = 1'b1;
          nxt_cur.state = TSX_FETCH;
        end
      end
      TSX_FETCH: begin
        if (fetch_valid_in) begin
          nxt_cur.fetch_req = 1'b0;
          nxt_cur.state = TSX_EXEC;
        end
      end
      TSX_EXEC: begin
        nxt_cur.state = TSX_FETCH;
        nxt_cur.fetch_req = 1'b1;
        // [R25] Absolute target, either direction; [R11] free reach.
        nxt_cur.pc = taken ? instr_target_in : pc_inc;
        case (instr_op_in)
          // [R1] [R2] Boolean update of the test register.
          TSX_OP_AND: nxt_cur.test_reg = cur_ff.test_reg & instr_operand_in;
          TSX_OP_OR: nxt_cur.test_reg = cur_ff.test_reg | instr_operand_in;
          TSX_OP_XOR: nxt_cur.test_reg = cur_ff.test_reg ^ instr_operand_in;
          // [R16] Force verdict.
          TSX_OP_SET_GOOD: nxt_cur.verdict_good = 1'b1;
          TSX_OP_SET_BAD: nxt_cur.verdict_good = 1'b0;
          // [R20] Text to display row two.
          TSX_OP_MESSAGE: begin
            nxt_cur.msg_valid = 1'b1;
            nxt_cur.msg_text = instr_msg_in;
            nxt_cur.msg_row = TSX_MSG_ROW;
          end
          // [R22] Stall in tenths of a second.
          TSX_OP_WAIT: begin
            if (instr_operand_in != TSX_ZERO) begin
              nxt_cur.wait_tenths = instr_operand_in;
              nxt_cur.wait_cyc = 32'h0000_0000;
              nxt_cur.fetch_req = 1'b0;
              nxt_cur.state = TSX_WAIT;
            end
          end
          // [R17] [R18] [R24] Segment end.
          TSX_OP_SEG_END: begin
            if (!cur_ff.verdict_good || instr_last_seg_in) begin
              nxt_cur.aborted = !cur_ff.verdict_good;
              nxt_cur.done = 1'b1;
              nxt_cur.fetch_req = 1'b0;
              nxt_cur.state = TSX_IDLE;
            end
          end
          // [R12] [R13] [R14] [R15] Raw-unit results are loaded as given.
          TSX_OP_TEST_BIT, TSX_OP_LOAD_RES: begin
            nxt_cur.meas_req = 1'b1;
            nxt_cur.meas_sel = instr_operand_in[7:0];
            nxt_cur.bit_only = instr_op_in == TSX_OP_TEST_BIT;
            nxt_cur.fetch_req = 1'b0;
            nxt_cur.state = TSX_RESULT;
          end
          // [R21] No-operation and unknown codes only advance.
          default: begin
          end
        endcase
      end
      TSX_WAIT: begin
        if (cur_ff.wait_cyc == 32'(TENTH_CYCLES - 1)) begin
          nxt_cur.wait_cyc = 32'h0000_0000;
          nxt_cur.wait_tenths = cur_ff.wait_tenths - TSX_WAIT_ONE;
          if (cur_ff.wait_tenths == TSX_WAIT_ONE) begin
            nxt_cur.fetch_req = 1'b1;
            nxt_cur.state = TSX_FETCH;
          end
        end else begin
          nxt_cur.wait_cyc = cur_ff.wait_cyc + 32'h0000_0001;
        end
      end
      TSX_RESULT: begin
        if (meas_done_in) begin
          // [R23] Single bit into bit zero, upper bits cleared.
          if (cur_ff.bit_only) begin
            nxt_cur.test_reg = {15'h0000, meas_bit_in};
          end else begin
            nxt_cur.test_reg = meas_result_in;
          end
          nxt_cur.fetch_req = 1'b1;
          nxt_cur.state = TSX_FETCH;
        end
      end
      default: nxt_cur.state = TSX_IDLE;
    endcase
    // Registered so the status pin never glitches while the state moves.
    nxt_cur.running = nxt_cur.state != TSX_IDLE;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.state <= TSX_IDLE;
      cur_ff.verdict_good <= 1'b1;
      cur_ff.msg_row <= TSX_MSG_ROW;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign fetch_addr_out = cur_ff.pc;
  assign fetch_req_out = cur_ff.fetch_req;
  assign meas_req_out = cur_ff.meas_req;
  assign meas_sel_out = cur_ff.meas_sel;
  assign msg_valid_out = cur_ff.msg_valid;
  assign msg_row_out = cur_ff.msg_row;
  assign msg_text_out = cur_ff.msg_text;
  assign test_reg_out = cur_ff.test_reg;
  assign verdict_good_out = cur_ff.verdict_good;
  assign running_out = cur_ff.running;
  assign aborted_out = cur_ff.aborted;
  assign done_out = cur_ff.done;

  // [R1] AND result.
  a_and_result: assert property ( // [R1]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_AND |=>
    test_reg_out == ($past(cur_ff.test_reg) & $past(instr_operand_in)))
    else $error("AND result wrong");
  // [R2] Full-width XOR.
  a_xor_result: assert property ( // [R2]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_XOR |=>
    test_reg_out == ($past(cur_ff.test_reg) ^ $past(instr_operand_in)))
    else $error("XOR result wrong");
  // [R3] Branches keep the register.
  a_branch_keeps: assert property ( // [R3]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in >= TSX_OP_ALWAYS &&
    instr_op_in <= TSX_OP_BITS_ANY |=> $stable(test_reg_out))
    else $error("branch changed test register");
  // [R5] Equal value branches.
  a_match_taken: assert property ( // [R5]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_MATCH &&
    cur_ff.test_reg == instr_operand_in |=>
    fetch_addr_out == $past(instr_target_in))
    else $error("match branch not taken");
  // [R6] Strict greater.
  a_above_strict: assert property ( // [R6]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_ABOVE &&
    cur_ff.test_reg == instr_operand_in |=> fetch_addr_out == $past(pc_inc))
    else $error("above taken on equal");
  // [R7] Strict less.
  a_below_strict: assert property ( // [R7]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_BELOW &&
    cur_ff.test_reg == instr_operand_in |=> fetch_addr_out == $past(pc_inc))
    else $error("below taken on equal");
  // [R10] Masked zero branches.
  a_mask_taken: assert property ( // [R10]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_BITS_CLEAR &&
    (cur_ff.test_reg & instr_operand_in) == TSX_ZERO |=>
    fetch_addr_out == $past(instr_target_in))
    else $error("bits-clear branch not taken");
  // [R12] Raw result loaded whole.
  a_raw_load: assert property ( // [R12]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_RESULT && meas_done_in && !cur_ff.bit_only |=>
    test_reg_out == $past(meas_result_in))
    else $error("raw result load wrong");
  // [R16] Forced bad verdict.
  a_verdict_set: assert property ( // [R16]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_SET_BAD |=>
    !verdict_good_out)
    else $error("verdict not forced bad");
  // [R17] Bad verdict aborts.
  a_seg_abort: assert property ( // [R17]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_SEG_END &&
    !verdict_good_out |=> aborted_out && !running_out)
    else $error("failed segment did not abort");
  // [R18] Good verdict continues.
  a_seg_cont: assert property ( // [R18]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_SEG_END &&
    verdict_good_out && !instr_last_seg_in |=> running_out && fetch_req_out)
    else $error("passed segment stopped");
  // [R19] Verdict branch taken.
  a_verdict_jump: assert property ( // [R19]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_VERDICT_GOOD &&
    verdict_good_out |=> fetch_addr_out == $past(instr_target_in))
    else $error("verdict branch not taken");
  // [R20] Message row.
  a_msg_row: assert property ( // [R20]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_MESSAGE |=>
    msg_valid_out && msg_row_out == TSX_MSG_ROW ##1 !msg_valid_out)
    else $error("message not sent to row two");
  // [R21] No-operation only advances.
  a_nop_advance: assert property ( // [R21]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_NOP |=>
    fetch_addr_out == $past(pc_inc) && $stable(test_reg_out))
    else $error("no-operation had an effect");
  // [R23] Single bit load.
  a_bit_load: assert property ( // [R23]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_RESULT && meas_done_in && cur_ff.bit_only |=>
    test_reg_out[15:1] == 15'h0000 && test_reg_out[0] == $past(meas_bit_in))
    else $error("bit test load wrong");
  // [R25] Taken jump loads target.
  a_jump_target: assert property ( // [R25]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_ALWAYS |=>
    fetch_addr_out == $past(instr_target_in))
    else $error("jump target not loaded");
  // [R22] Wait does not fetch early.
  a_wait_stall: assert property ( // [R22]
    @(posedge core_clk_in) disable iff (!rst_n)
    cur_ff.state == TSX_EXEC && instr_op_in == TSX_OP_WAIT &&
    instr_operand_in != TSX_ZERO |=> !fetch_req_out [*8])
    else $error("wait released too early");
endmodule // tsx_executor
`default_nettype wire

// ===== logic/tsx_pkg.sv
package tsx_pkg;
  localparam int TSX_DW = 16;
  localparam int TSX_AW = 12;
  localparam int TSX_OPW = 6;
  localparam int TSX_MSGW = 8;

  localparam logic [15:0] TSX_ZERO = 16'h0000;
  localparam logic [11:0] TSX_PC_RST = 12'h000;
  localparam logic [15:0] TSX_WAIT_ONE = 16'h0001;

  // Raw result units, kept for reference by the measurement side.
  localparam int TSX_TIME_STEPS_PER_NS = 64;
  localparam int TSX_AMPL_MV_PER_LSB = 10;
  localparam int TSX_FREQ_STEPS_PER_HZ = 64;
  localparam int TSX_PHASE_STEPS_PER_TURN = 512;

  localparam int TSX_CLK_HZ = 50_000_000;
  localparam int TSX_TENTH_MS = 100;
  localparam int TSX_TENTH_CYC = TSX_CLK_HZ / 1000 * TSX_TENTH_MS;

  localparam logic [5:0] TSX_OP_NOP = 6'h00;
  localparam logic [5:0] TSX_OP_AND = 6'h01;
  localparam logic [5:0] TSX_OP_OR = 6'h02;
  localparam logic [5:0] TSX_OP_XOR = 6'h03;
  localparam logic [5:0] TSX_OP_ALWAYS = 6'h04;
  localparam logic [5:0] TSX_OP_MATCH = 6'h05;
  localparam logic [5:0] TSX_OP_MISMATCH = 6'h06;
  localparam logic [5:0] TSX_OP_ABOVE = 6'h07;
  localparam logic [5:0] TSX_OP_BELOW = 6'h08;
  localparam logic [5:0] TSX_OP_AT_LEAST = 6'h09;
  localparam logic [5:0] TSX_OP_AT_MOST = 6'h0a;
  localparam logic [5:0] TSX_OP_EMPTY = 6'h0b;
  localparam logic [5:0] TSX_OP_NONEMPTY = 6'h0c;
  localparam logic [5:0] TSX_OP_BITS_CLEAR = 6'h0d;
  localparam logic [5:0] TSX_OP_BITS_ANY = 6'h0e;
  localparam logic [5:0] TSX_OP_SET_GOOD = 6'h0f;
  localparam logic [5:0] TSX_OP_SET_BAD = 6'h10;
  localparam logic [5:0] TSX_OP_VERDICT_GOOD = 6'h11;
  localparam logic [5:0] TSX_OP_VERDICT_BAD = 6'h12;
  localparam logic [5:0] TSX_OP_MESSAGE = 6'h13;
  localparam logic [5:0] TSX_OP_WAIT = 6'h14;
  localparam logic [5:0] TSX_OP_SEG_END = 6'h15;
  localparam logic [5:0] TSX_OP_TEST_BIT = 6'h16;
  localparam logic [5:0] TSX_OP_LOAD_RES = 6'h17;

  localparam logic [7:0] TSX_MSG_ROW = 8'h02;

  typedef enum logic [4:0] {
    TSX_IDLE = 5'b00001,
    TSX_FETCH = 5'b00010,
    TSX_EXEC = 5'b00100,
    TSX_WAIT = 5'b01000,
    TSX_RESULT = 5'b10000
  } tsx_state_t;
endpackage

// ===== sim/tsx_store_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sequence store and measurement stand-in; lat_in stretches each answer.
module tsx_store_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] lat_in,
  input wire logic fetch_req_in,
  input wire logic [11:0] fetch_addr_in,
  output logic fetch_valid_out,
  output logic [42:0] word_out,
  input wire logic meas_req_in,
  input wire logic [15:0] res_in,
  input wire logic bit_in,
  output logic meas_done_out,
  output logic [15:0] meas_result_out,
  output logic meas_bit_out
);
  logic [42:0] mem [0:63];
  logic [3:0] cnt;
  logic [1:0] hold;
  logic [4:0] mcnt;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fetch_valid_out <= 1'h0;
      word_out <= '0;
      cnt <= 4'h0;
      hold <= 2'h0;
      mcnt <= 5'h00;
      meas_done_out <= 1'h0;
      meas_result_out <= 16'h0000;
      meas_bit_out <= 1'h0;
    end else begin
      fetch_valid_out <= 1'h0;
      meas_done_out <= 1'h0;
      if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end
      // Fields are spoilt once their hold time ends, so late reads show up.
      if (hold == 2'h1) begin
        word_out <= ~word_out;
      end
      if (fetch_req_in && !fetch_valid_out && hold < 2'h2) begin
        if (cnt < lat_in) begin
          cnt <= cnt + 4'h1;
        end else begin
          cnt <= 4'h0;
          fetch_valid_out <= 1'h1;
          word_out <= mem[fetch_addr_in[5:0]];
          hold <= 2'h3;
        end
      end
      if (meas_req_in) begin
        mcnt <= {1'h0, lat_in} + 5'h01;
      end else if (mcnt == 5'h01) begin
        mcnt <= 5'h00;
        meas_done_out <= 1'h1;
        meas_result_out <= res_in;
        meas_bit_out <= bit_in;
      end else if (mcnt != 5'h00) begin
        mcnt <= mcnt - 5'h01;
      end else begin
        meas_result_out <= ~meas_result_out;
        meas_bit_out <= ~meas_bit_out;
      end
    end
  end
endmodule // tsx_store_model
`default_nettype wire

// ===== sim/test_sequence_executor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sequence_executor_tb_top;
  import tsx_pkg::*;
  localparam int TENTH = 10;
  logic clk, nrst_in, start_in, bit_v, fv, req, mreq, mdone, mbit;
  logic mvalid, good, run_o, abt, done;
  logic [3:0] lat;
  logic [42:0] word;
  logic [11:0] addr;
  logic [7:0] sel, row, text, last_text, last_row, last_sel;
  logic [15:0] res_v, mres, treg;
  int error_cnt, compares, msg_cnt, cycles, n0, n5;
  tsx_executor #(.TENTH_CYCLES(TENTH)) u_tsx_executor (
    .core_clk_in(clk), .nrst_in(nrst_in), .start_in(start_in),
    .fetch_addr_out(addr), .fetch_req_out(req), .fetch_valid_in(fv),
    .instr_op_in(word[42:37]), .instr_operand_in(word[36:21]),
    .instr_target_in(word[20:9]), .instr_last_seg_in(word[8]),
    .instr_msg_in(word[7:0]), .meas_req_out(mreq), .meas_sel_out(sel),
    .meas_done_in(mdone), .meas_result_in(mres), .meas_bit_in(mbit),
    .msg_valid_out(mvalid), .msg_row_out(row), .msg_text_out(text),
    .test_reg_out(treg), .verdict_good_out(good), .running_out(run_o),
    .aborted_out(abt), .done_out(done));
  tsx_store_model u_tsx_store_model (
    .clk_in(clk), .nrst_in(nrst_in), .lat_in(lat), .fetch_req_in(req),
    .fetch_addr_in(addr), .fetch_valid_out(fv), .word_out(word),
    .meas_req_in(mreq), .res_in(res_v), .bit_in(bit_v),
    .meas_done_out(mdone), .meas_result_out(mres), .meas_bit_out(mbit));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (mvalid === 1'h1) begin
      msg_cnt++;
      last_text = text;
      last_row = row;
    end
    if (mreq === 1'h1) begin
      last_sel = sel;
    end
    // A hung sequence must still reach the verdict.
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input int a, input logic [5:0] o, input logic [15:0] v,
                     input logic [11:0] t, input logic l,
                     input logic [7:0] m = 8'h00);
    u_tsx_store_model.mem[a] = {o, v, t, l, m};
  endtask
  task automatic run(output int n);
    n = 0;
    msg_cnt = 0;
    start_in <= 1'h1;
    @(posedge clk);
    start_in <= 1'h0;
    repeat (2) @(posedge clk);
    while (n < 2000 && done !== 1'h1 && abt !== 1'h1) begin
      @(posedge clk);
      n++;
    end
    check("finished", {15'h0000, n < 2000}, 16'h0001);
  endtask
  task automatic br(input logic [5:0] o, input logic [15:0] r,
                    input logic [15:0] v, input logic tk);
    int n;
    res_v <= r;
    put(0, TSX_OP_LOAD_RES, 16'h0000, 12'h000, 1'h0);
    put(1, o, v, 12'h003, 1'h0);
    put(2, TSX_OP_SET_BAD, 16'h0000, 12'h000, 1'h0);
    put(3, TSX_OP_SEG_END, 16'h0000, 12'h000, 1'h1);
    run(n);
    check("taken", {15'h0000, ~abt}, {15'h0000, tk});
    check("test_reg", treg, r);
  endtask
  task automatic bool_ops();
    int n;
    res_v <= 16'hf0f0;
    put(0, TSX_OP_LOAD_RES, 16'h0033, 12'h000, 1'h0);
    put(1, TSX_OP_AND, 16'h0ff0, 12'h000, 1'h0);
    put(2, TSX_OP_OR, 16'h1001, 12'h000, 1'h0);
    put(3, TSX_OP_XOR, 16'hffff, 12'h000, 1'h0);
    put(4, TSX_OP_SEG_END, 16'h0000, 12'h000, 1'h1);
    run(n);
    check("bool", treg, 16'hef0e);
    check("sel", {8'h00, last_sel}, 16'h0033);
  endtask
  task automatic back_jump();
    int n;
    res_v <= 16'hfffe;
    bit_v <= 1'h1;
    put(0, TSX_OP_LOAD_RES, 16'h0000, 12'h000, 1'h0);
    put(1, TSX_OP_ALWAYS, 16'h0000, 12'h004, 1'h0);
    put(2, TSX_OP_TEST_BIT, 16'h0000, 12'h000, 1'h0);
    put(3, TSX_OP_SEG_END, 16'h0000, 12'h000, 1'h1);
    put(4, TSX_OP_ALWAYS, 16'h0000, 12'h002, 1'h0);
    run(n);
    check("bit_load", treg, 16'h0001);
  endtask
  task automatic wait_run(input logic [15:0] w, output int n);
    res_v <= 16'h5a5a;
    put(0, TSX_OP_LOAD_RES, 16'h0000, 12'h000, 1'h0);
    put(1, TSX_OP_NOP, 16'hffff, 12'h000, 1'h0);
    put(2, 6'h3f, 16'h0000, 12'h000, 1'h0);
    put(3, TSX_OP_WAIT, w, 12'h000, 1'h0);
    put(4, TSX_OP_SEG_END, 16'h0000, 12'h000, 1'h1);
    run(n);
    check("nop", {treg[15:1], ~abt}, 16'h5a5b);
    check("nop_msg", 16'(msg_cnt), 16'h0000);
  endtask
  task automatic seg_flow(input logic [5:0] first, input logic [5:0] third);
    int n;
    put(0, first, 16'h0000, 12'h000, 1'h0);
    put(1, TSX_OP_MESSAGE, 16'h0000, 12'h000, 1'h0, 8'h5a);
    put(2, third, 16'h0000, 12'h000, 1'h0);
    put(3, TSX_OP_SEG_END, 16'h0000, 12'h000, 1'h0);
    put(4, TSX_OP_MESSAGE, 16'h0000, 12'h000, 1'h0, 8'ha5);
    put(5, TSX_OP_SEG_END, 16'h0000, 12'h000, 1'h1);
    run(n);
  endtask
  initial begin
    nrst_in = 1'h0;
    start_in = 1'h0;
    lat = 4'h0;
    res_v = 16'h0000;
    bit_v = 1'h0;
    repeat (3) @(posedge clk);
    nrst_in <= 1'h1;
    repeat (5) @(posedge clk);
    check("rst", {good, done, abt, run_o, 4'h0, row}, 16'h8002);
    bool_ops();
    br(TSX_OP_ALWAYS, 16'h0000, 16'hffff, 1'h1);
    br(TSX_OP_MATCH, 16'h1234, 16'h1234, 1'h1);
    br(TSX_OP_MATCH, 16'h1234, 16'h1235, 1'h0);
    br(TSX_OP_MISMATCH, 16'h1234, 16'h1234, 1'h0);
    br(TSX_OP_ABOVE, 16'h1040, 16'h1040, 1'h0);
    br(TSX_OP_ABOVE, 16'h8000, 16'h0001, 1'h1);
    br(TSX_OP_BELOW, 16'h0018, 16'h0018, 1'h0);
    br(TSX_OP_BELOW, 16'h0017, 16'h0018, 1'h1);
    br(TSX_OP_AT_LEAST, 16'h0040, 16'h0040, 1'h1);
    br(TSX_OP_AT_MOST, 16'h0041, 16'h0040, 1'h0);
    br(TSX_OP_EMPTY, 16'h0000, 16'hffff, 1'h1);
    br(TSX_OP_NONEMPTY, 16'h8000, 16'h0000, 1'h1);
    br(TSX_OP_BITS_CLEAR, 16'h00f0, 16'h0f00, 1'h1);
    br(TSX_OP_BITS_ANY, 16'h00f0, 16'h0f00, 1'h0);
    br(TSX_OP_VERDICT_GOOD, 16'h0003, 16'h0000, 1'h1);
    br(TSX_OP_VERDICT_BAD, 16'h0003, 16'h0000, 1'h0);
    lat <= 4'h3;
    back_jump();
    wait_run(16'h0000, n0);
    wait_run(16'h0005, n5);
    check("wait", 16'(n5 - n0), 16'(5 * TENTH));
    lat <= 4'h1;
    seg_flow(TSX_OP_SEG_END, TSX_OP_SET_BAD);
    check("seg_bad", {abt, good, 6'(msg_cnt), last_text}, 16'h815a);
    check("row", {8'h00, last_row}, {8'h00, TSX_MSG_ROW});
    seg_flow(TSX_OP_SET_BAD, TSX_OP_SET_GOOD);
    check("seg_good", {abt, good, 6'(msg_cnt), last_text}, 16'h42a5);
    give_verdict();
  end
endmodule // test_sequence_executor_tb_top
`default_nettype wire
